// file: core/adio_pkg.sv
// Constants, field layouts and types shared by the address decode and control glue
package adio_pkg;

  // System clock and timing
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned RST_DELAY_MS     = 300;
  localparam int unsigned RST_DELAY_CYCLES = (CLK_HZ / 1000) * RST_DELAY_MS;

  // Master crystal and derived processor / serial clock
  localparam int unsigned MASTER_CLK_HZ    = 3_686_400;
  localparam int unsigned DIV_RATIO        = 2;
  localparam int unsigned CPU_CLK_HZ       = MASTER_CLK_HZ / DIV_RATIO;

  // Memory map
  localparam logic [15:0] RAM_FIRST        = 16'h0000;
  localparam logic [15:0] RAM_LAST         = 16'h7FFF;
  localparam logic [15:0] IO_FIRST         = 16'h8000;
  localparam logic [15:0] IO_LAST          = 16'h80FF;
  localparam logic [15:0] ROM_FIRST        = 16'h8100;
  localparam logic [15:0] ROM_LAST         = 16'hFFFF;
  localparam logic [7:0]  IO_PAGE          = 8'h80;
  localparam int unsigned IO_BLOCK_SIZE    = 32;
  localparam int unsigned PERIPH_COUNT     = 8;
  localparam int unsigned SEL_LSB          = 5;
  localparam int unsigned SEL_MSB          = 7;

  // Peripheral select indices, ascending 32-address blocks from the page base
  localparam logic [2:0] P_ANALOG_OUT_DAC  = 3'h0;
  localparam logic [2:0] P_MASS_SCALE_DAC  = 3'h1;
  localparam logic [2:0] P_DUAL_PROG_DAC   = 3'h2;
  localparam logic [2:0] P_ADC             = 3'h3;
  localparam logic [2:0] P_RTC             = 3'h4;
  localparam logic [2:0] P_SERIAL_LINK     = 3'h5;
  localparam logic [2:0] P_DIO_GROUP1      = 3'h6;
  localparam logic [2:0] P_DIO_GROUP2      = 3'h7;
  localparam logic [15:0] RTC_FIRST        = 16'h8080;
  localparam logic [15:0] RTC_LAST         = 16'h809F;

  // Register offsets on the plain register port
  localparam logic [3:0] REG_CTRL          = 4'h0;
  localparam logic [3:0] REG_STATUS        = 4'h4;
  localparam logic [3:0] REG_DECODE        = 4'h8;

  // Control register fields
  localparam int unsigned CTRL_TOTAL_PRESSURE_RF_CTRL      = 0;
  localparam int unsigned CTRL_FIL_SEL     = 1;
  localparam int unsigned CTRL_OUTGAS      = 2;
  localparam int unsigned CTRL_EM_EN       = 3;
  localparam int unsigned CTRL_PREAMP      = 4;
  localparam int unsigned CTRL_BEAM_OFF    = 5;
  localparam int unsigned CTRL_WIDTH       = 6;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;

  // Status register fields
  localparam int unsigned ST_EMISSION      = 0;
  localparam int unsigned ST_SUPPLY_GOOD   = 1;
  localparam int unsigned ST_MAIN_LOW      = 2;
  localparam int unsigned ST_SYS_RST_N     = 3;
  localparam int unsigned ST_CPU_CLK       = 4;

  typedef enum logic [1:0] {
    ADIO_RGN_RAM,
    ADIO_RGN_IO,
    ADIO_RGN_ROM
  } adio_region_e;

  typedef enum logic {
    ADIO_RST_HOLD,
    ADIO_RST_RUN
  } adio_rst_state_e;

endpackage : adio_pkg

// file: core/adio_clk_div2.sv
// Divide-by-two of the synchronously sampled master clock
`timescale 1ns/1ps
`default_nettype none
module adio_clk_div2 (
  input  wire logic clock,
  input  wire logic clk_en,
  input  wire logic rst_n,
  input  wire logic master_clk_in,
  output var  logic div_clk
);

  typedef struct packed {
    logic prev;
    logic div;
  } adio_div_s;

  adio_div_s st_q;
  adio_div_s st_d;

  always_comb begin
    st_d      = st_q;
    st_d.prev = master_clk_in;
    if (master_clk_in && !st_q.prev) begin
      st_d.div = ~st_q.div;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign div_clk = st_q.div;

  sequence s_master_rise;
    clk_en && !st_q.prev && master_clk_in;
  endsequence

  property p_div_toggle;
    @(posedge clock) disable iff (!rst_n)
      s_master_rise |=> (div_clk != $past(div_clk));
  endproperty

  AST_DIV_TOGGLE: assert property (p_div_toggle)
    else $error("divided clock missed a master rising edge");

  AST_DIV_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && !(master_clk_in && !st_q.prev)) |=> $stable(div_clk))
    else $error("divided clock moved without a master rising edge");

endmodule : adio_clk_div2
`default_nettype wire

// file: core/adio_reset_gen.sv
// Power-on and supply-monitor reset with a long release delay
`timescale 1ns/1ps
`default_nettype none
module adio_reset_gen #(
  parameter int unsigned DELAY_CYCLES = adio_pkg::RST_DELAY_CYCLES
) (
  input  wire logic clock,
  input  wire logic clk_en,
  input  wire logic rst_n,
  input  wire logic supply_good,
  output var  logic sys_rst_n
);

  localparam int unsigned CW = $clog2(DELAY_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY_CYCLES - 1);

  typedef struct packed {
    adio_pkg::adio_rst_state_e state;
    logic [CW-1:0]             cnt;
    logic                      rst_n;
  } adio_rst_s;

  adio_rst_s st_q;
  adio_rst_s st_d;

  always_comb begin
    st_d = st_q;
    case (st_q.state)
      adio_pkg::ADIO_RST_HOLD: begin
        st_d.rst_n = 1'b0;
        if (!supply_good) begin
          st_d.cnt = '0;
        end else if (st_q.cnt == LAST) begin
          st_d.rst_n = 1'b1;
          st_d.state = adio_pkg::ADIO_RST_RUN;
        end else begin
          st_d.cnt = st_q.cnt + CW'(1);
        end
      end
      adio_pkg::ADIO_RST_RUN: begin
        if (!supply_good) begin
          st_d.rst_n = 1'b0;
          st_d.cnt   = '0;
          st_d.state = adio_pkg::ADIO_RST_HOLD;
        end
      end
      default: begin
        st_d = '0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign sys_rst_n = st_q.rst_n;

  AST_RST_SUPPLY: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && !supply_good) |=> !sys_rst_n)
    else $error("reset not asserted on supply fault");

  AST_RST_DELAY: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && !sys_rst_n && st_q.cnt != LAST) |=> !sys_rst_n)
    else $error("reset released before the delay ran out");

endmodule : adio_reset_gen
`default_nettype wire

// file: core/adio_glue.sv
// Address decode, clock divide, reset and relay control glue of the controller board
`timescale 1ns/1ps
`default_nettype none
module adio_glue #(
  parameter int unsigned RST_DELAY_CYCLES = adio_pkg::RST_DELAY_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        clk_en,
  input  wire logic        rst_n,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [7:0]  reg_rdata,
  input  wire logic        master_clk_in,
  input  wire logic        supply_good,
  input  wire logic        main_power_low,
  input  wire logic        emission_good,
  output var  logic        cpu_clk_out,
  output var  logic        sys_rst_n,
  output var  logic        ram_ce_n,
  output var  logic        io_page_n,
  output var  logic        rom_ce_n,
  output var  logic [7:0]  periph_sel_n,
  output var  logic        total_pressure_rf_out,
  output var  logic        filament_relay_drive,
  output var  logic        outgas_relay_drive,
  output var  logic        electron_multiplier_out,
  output var  logic        preamp_gain_relay_drive,
  output var  logic        beam_blank,
  output var  logic        fil1_status,
  output var  logic        fil2_status
);

  typedef struct packed {
    logic [7:0]                ctrl;
    logic [7:0]                rdata;
    adio_pkg::adio_region_e    region;
    logic [2:0]                periph_idx;
    logic                      ram_ce_n;
    logic                      io_page_n;
    logic                      rom_ce_n;
    logic [7:0]                periph_n;
    logic                      total_pressure_rf_ctrl;
    logic                      fil_relay;
    logic                      outgas_relay;
    logic                      em_out;
    logic                      preamp_relay;
    logic                      beam_blank;
    logic                      fil1;
    logic                      fil2;
  } adio_glue_s;

  localparam adio_glue_s ST_RESET = '{
    ctrl:         adio_pkg::CTRL_RESET,
    rdata:        8'h00,
    region:       adio_pkg::ADIO_RGN_RAM,
    periph_idx:   3'h0,
    ram_ce_n:     1'b1,
    io_page_n:    1'b1,
    rom_ce_n:     1'b1,
    periph_n:     8'hFF,
    total_pressure_rf_ctrl:       ~adio_pkg::CTRL_RESET[adio_pkg::CTRL_TOTAL_PRESSURE_RF_CTRL],
    fil_relay:    ~adio_pkg::CTRL_RESET[adio_pkg::CTRL_FIL_SEL],
    outgas_relay: ~adio_pkg::CTRL_RESET[adio_pkg::CTRL_OUTGAS],
    em_out:       ~adio_pkg::CTRL_RESET[adio_pkg::CTRL_EM_EN],
    preamp_relay: ~adio_pkg::CTRL_RESET[adio_pkg::CTRL_PREAMP],
    beam_blank:   ~adio_pkg::CTRL_RESET[adio_pkg::CTRL_BEAM_OFF],
    fil1:         1'b0,
    fil2:         1'b0
  };

  adio_glue_s st_q;
  adio_glue_s st_d;

  logic       is_ram;
  logic       is_io;
  logic       is_rom;
  logic [2:0] sel_idx;

  // Divided processor and serial clock
  adio_clk_div2 u_clk_div (
    .clock         (clock),
    .clk_en        (clk_en),
    .rst_n         (rst_n),
    .master_clk_in (master_clk_in),
    .div_clk       (cpu_clk_out)
  );

  // Power-on and supply-monitor reset
  adio_reset_gen #(
    .DELAY_CYCLES (RST_DELAY_CYCLES)
  ) u_reset_gen (
    .clock       (clock),
    .clk_en      (clk_en),
    .rst_n       (rst_n),
    .supply_good (supply_good),
    .sys_rst_n   (sys_rst_n)
  );

  // Region decode of the 64K space
  always_comb begin
    is_ram  = (cpu_addr[15] == 1'b0);
    is_io   = (cpu_addr[15:8] == adio_pkg::IO_PAGE);
    is_rom  = cpu_addr[15] && !is_io;
    sel_idx = cpu_addr[adio_pkg::SEL_MSB:adio_pkg::SEL_LSB];
  end

  always_comb begin
    st_d = st_q;

    // Software write of the control bits
    if (reg_wr && reg_addr == adio_pkg::REG_CTRL) begin
      st_d.ctrl = {2'b00, reg_wdata[adio_pkg::CTRL_WIDTH-1:0]};
    end

    // Chip and peripheral selects, all active low
    st_d.ram_ce_n  = !(is_ram && !main_power_low);
    st_d.io_page_n = !is_io;
    st_d.rom_ce_n  = !is_rom;
    st_d.periph_n  = 8'hFF;
    if (is_io) begin
      st_d.periph_n[sel_idx] = 1'b0;
    end
    if (is_ram) begin
      st_d.region = adio_pkg::ADIO_RGN_RAM;
    end else if (is_io) begin
      st_d.region = adio_pkg::ADIO_RGN_IO;
    end else begin
      st_d.region = adio_pkg::ADIO_RGN_ROM;
    end
    st_d.periph_idx = sel_idx;

    // Inverting drivers towards the relays and the RF head
    st_d.total_pressure_rf_ctrl       = ~st_d.ctrl[adio_pkg::CTRL_TOTAL_PRESSURE_RF_CTRL];
    st_d.fil_relay    = ~st_d.ctrl[adio_pkg::CTRL_FIL_SEL];
    st_d.outgas_relay = ~st_d.ctrl[adio_pkg::CTRL_OUTGAS];
    st_d.em_out       = ~st_d.ctrl[adio_pkg::CTRL_EM_EN];
    st_d.preamp_relay = ~st_d.ctrl[adio_pkg::CTRL_PREAMP];
    st_d.beam_blank   = ~st_d.ctrl[adio_pkg::CTRL_BEAM_OFF];

    // Emission status shown only on the indicator of the filament in use
    st_d.fil1 = emission_good && !st_q.ctrl[adio_pkg::CTRL_FIL_SEL];
    st_d.fil2 = emission_good && st_q.ctrl[adio_pkg::CTRL_FIL_SEL];

    // Read data stand for the one cycle after the read strobe
    st_d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        adio_pkg::REG_CTRL: begin
          st_d.rdata = st_q.ctrl;
        end
        adio_pkg::REG_STATUS: begin
          st_d.rdata[adio_pkg::ST_EMISSION]    = emission_good;
          st_d.rdata[adio_pkg::ST_SUPPLY_GOOD] = supply_good;
          st_d.rdata[adio_pkg::ST_MAIN_LOW]    = main_power_low;
          st_d.rdata[adio_pkg::ST_SYS_RST_N]   = sys_rst_n;
          st_d.rdata[adio_pkg::ST_CPU_CLK]     = cpu_clk_out;
        end
        adio_pkg::REG_DECODE: begin
          st_d.rdata = {3'b000, st_q.periph_idx, st_q.region};
        end
        default: begin
          st_d.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_RESET;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign reg_rdata               = st_q.rdata;
  assign ram_ce_n                = st_q.ram_ce_n;
  assign io_page_n               = st_q.io_page_n;
  assign rom_ce_n                = st_q.rom_ce_n;
  assign periph_sel_n            = st_q.periph_n;
  assign total_pressure_rf_out   = st_q.total_pressure_rf_ctrl;
  assign filament_relay_drive    = st_q.fil_relay;
  assign outgas_relay_drive      = st_q.outgas_relay;
  assign electron_multiplier_out = st_q.em_out;
  assign preamp_gain_relay_drive = st_q.preamp_relay;
  assign beam_blank              = st_q.beam_blank;
  assign fil1_status             = st_q.fil1;
  assign fil2_status             = st_q.fil2;

  default clocking cb @(posedge clock);
  endclocking

  default disable iff (!rst_n);

  sequence s_ram_addr;
    clk_en && cpu_addr <= adio_pkg::RAM_LAST;
  endsequence

  sequence s_io_addr;
    clk_en && cpu_addr >= adio_pkg::IO_FIRST && cpu_addr <= adio_pkg::IO_LAST;
  endsequence

  sequence s_rom_addr;
    clk_en && cpu_addr >= adio_pkg::ROM_FIRST;
  endsequence

  AST_RAM_SELECT: assert property (
    (s_ram_addr ##0 !main_power_low) |=> (!ram_ce_n && rom_ce_n && io_page_n))
    else $error("RAM range did not select RAM alone");

  AST_IO_SELECT: assert property (
    s_io_addr |=> (!io_page_n && ram_ce_n && rom_ce_n))
    else $error("I/O page did not select I/O alone");

  AST_ROM_SELECT: assert property (
    s_rom_addr |=> (!rom_ce_n && ram_ce_n && io_page_n))
    else $error("ROM range did not enable ROM alone");

  AST_ROM_EXCLUDE: assert property (
    ($past(clk_en) && !rom_ce_n)
      |-> $past(cpu_addr[15]) && ($past(cpu_addr[15:8]) != adio_pkg::IO_PAGE))
    else $error("ROM enabled outside its range");

  AST_PERIPH_ONEHOT: assert property (
    s_io_addr |=> ($countones(~periph_sel_n) == 1))
    else $error("I/O access did not give exactly one peripheral select");

  AST_PERIPH_IDLE: assert property (
    (clk_en && cpu_addr[15:8] != adio_pkg::IO_PAGE) |=> (periph_sel_n == 8'hFF))
    else $error("peripheral selected outside the I/O page");

  AST_PERIPH_MAP: assert property (
    s_io_addr |=> !periph_sel_n[$past(cpu_addr[7:5])])
    else $error("peripheral select not at its 32-address block");

  AST_RTC_BLOCK: assert property (
    (clk_en && cpu_addr >= adio_pkg::RTC_FIRST && cpu_addr <= adio_pkg::RTC_LAST)
      |=> !periph_sel_n[adio_pkg::P_RTC])
    else $error("clock block not selected in its range");

  AST_ONE_SELECT: assert property (
    $countones({~ram_ce_n, ~rom_ce_n, ~io_page_n}) <= 1)
    else $error("more than one memory select active");

  AST_RAM_BLOCKED: assert property (
    (clk_en && main_power_low) |=> ram_ce_n)
    else $error("RAM enabled during main supply loss");

  AST_TOTAL_PRESSURE_RF_CTRL: assert property (
    clk_en |=> (total_pressure_rf_out == !st_q.ctrl[adio_pkg::CTRL_TOTAL_PRESSURE_RF_CTRL]))
    else $error("RF control output not inverse of its bit");

  AST_FIL_RELAY: assert property (
    clk_en |=> (filament_relay_drive == !st_q.ctrl[adio_pkg::CTRL_FIL_SEL]))
    else $error("filament relay drive not inverse of select");

  AST_FIL_STATUS: assert property (
    clk_en |=> (fil1_status == ($past(emission_good) && !$past(st_q.ctrl[adio_pkg::CTRL_FIL_SEL])))
      && (fil2_status == ($past(emission_good) && $past(st_q.ctrl[adio_pkg::CTRL_FIL_SEL]))))
    else $error("filament status not gated by selected filament");

  AST_OUTGAS: assert property (
    clk_en |=> (outgas_relay_drive == !st_q.ctrl[adio_pkg::CTRL_OUTGAS]))
    else $error("outgas relay drive not inverse of mode");

  AST_EM_OUT: assert property (
    clk_en |=> (electron_multiplier_out == !st_q.ctrl[adio_pkg::CTRL_EM_EN]))
    else $error("multiplier output not inverse of enable");

  AST_PREAMP: assert property (
    clk_en |=> (preamp_gain_relay_drive == !st_q.ctrl[adio_pkg::CTRL_PREAMP]))
    else $error("preamp relay drive not inverse of gain select");

  AST_BEAM: assert property (
    (clk_en && reg_wr && reg_addr == adio_pkg::REG_CTRL)
      |=> (beam_blank == !$past(reg_wdata[adio_pkg::CTRL_BEAM_OFF])))
    else $error("beam blank not inverse of written bit");

  AST_SUPPLY_RESET: assert property (
    (clk_en && !supply_good) |=> !sys_rst_n)
    else $error("system reset not asserted on supply fault");

  AST_READ_ONE_CYCLE: assert property (
    (clk_en && !reg_rd) |=> (reg_rdata == 8'h00))
    else $error("read data present without a read");

  sequence s_ctrl_read;
    clk_en && reg_rd && reg_addr == adio_pkg::REG_CTRL;
  endsequence

  sequence s_decode_read;
    clk_en && reg_rd && reg_addr == adio_pkg::REG_DECODE;
  endsequence

  AST_CTRL_HOLD: assert property (
    !(clk_en && reg_wr && reg_addr == adio_pkg::REG_CTRL) |=> $stable(st_q.ctrl))
    else $error("control bits moved without a control write");

  AST_CTRL_READBACK: assert property (
    s_ctrl_read |=> (reg_rdata == $past(st_q.ctrl)))
    else $error("control read did not return the control bits");

  AST_DECODE_READ: assert property (
    s_decode_read |=> (reg_rdata == {3'b000, $past(st_q.periph_idx), $past(st_q.region)}))
    else $error("decode read did not return the last decode");

  AST_UNMAPPED_READ: assert property (
    (clk_en && reg_rd && reg_addr != adio_pkg::REG_CTRL && reg_addr != adio_pkg::REG_STATUS
      && reg_addr != adio_pkg::REG_DECODE) |=> (reg_rdata == 8'h00))
    else $error("unmapped register read returned data");

  AST_STATUS_READ: assert property (
    (clk_en && reg_rd && reg_addr == adio_pkg::REG_STATUS)
      |=> (reg_rdata[adio_pkg::ST_SUPPLY_GOOD] == $past(supply_good))
        && (reg_rdata[adio_pkg::ST_MAIN_LOW] == $past(main_power_low)))
    else $error("status read did not show the supply inputs");

  AST_PERIPH_IN_PAGE: assert property (
    (periph_sel_n != 8'hFF) |-> !io_page_n)
    else $error("peripheral selected without the I/O page");

endmodule : adio_glue
`default_nettype wire

// file: verification/adio_cpu_model.sv
// Processor-side model that drives the address bus of the glue block
`timescale 1ns/1ps
`default_nettype none
module adio_cpu_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        sys_rst_n,
  input  wire logic        fetch_time,
  input  wire logic [15:0] next_addr,
  output var  logic [15:0] cpu_addr
);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cpu_addr <= 16'hFFFF;
    end else if (!sys_rst_n) begin
      // A processor held in reset puts no meaningful address out
      cpu_addr <= ~cpu_addr;
    end else if (fetch_time) begin
      cpu_addr <= adio_pkg::RTC_FIRST | {11'h000, next_addr[4:0]};
    end else begin
      cpu_addr <= next_addr;
    end
  end
endmodule : adio_cpu_model
`default_nettype wire

// file: verification/address_decode_and_control_io_tb.sv
// Self-checking testbench of the address decode and control glue
`timescale 1ns/1ps
`default_nettype none
module address_decode_and_control_io_tb;
  logic        clock = 1'b0;
  logic        rst_n, clk_en, reg_wr, reg_rd, master_clk_in = 1'b0;
  logic        supply_good, main_power_low, emission_good, fetch_time;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rd, v;
  logic [15:0] cpu_addr, next_addr;
  logic        cpu_clk_out, sys_rst_n, ram_ce_n, io_page_n, rom_ce_n;
  logic [7:0]  periph_sel_n;
  logic        tp, fr, og, em, pg, bb, fil1_status, fil2_status;
  logic        m_q, c_q, cnt_on;
  int          n_mismatch = 0, tests_run = 0, ph = 0, m_rise = 0, c_tog = 0;
  logic [15:0] tbl [14] = '{16'h0000, 16'h7FFF, 16'h8000, 16'h801F, 16'h8020, 16'h8040,
                            16'h8060, 16'h809F, 16'h80A0, 16'h80C0, 16'h80E0, 16'h80FF,
                            16'h8100, 16'hFFFF};

  always #10 clock = ~clock;

  adio_cpu_model cpu_u (.clock(clock), .rst_n(rst_n), .sys_rst_n(sys_rst_n),
    .fetch_time(fetch_time), .next_addr(next_addr), .cpu_addr(cpu_addr));

  adio_glue #(.RST_DELAY_CYCLES(16)) dut_u (.clock(clock), .clk_en(clk_en), .rst_n(rst_n),
    .cpu_addr(cpu_addr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .master_clk_in(master_clk_in),
    .supply_good(supply_good), .main_power_low(main_power_low),
    .emission_good(emission_good), .cpu_clk_out(cpu_clk_out), .sys_rst_n(sys_rst_n),
    .ram_ce_n(ram_ce_n), .io_page_n(io_page_n), .rom_ce_n(rom_ce_n),
    .periph_sel_n(periph_sel_n), .total_pressure_rf_out(tp), .filament_relay_drive(fr),
    .outgas_relay_drive(og), .electron_multiplier_out(em),
    .preamp_gain_relay_drive(pg), .beam_blank(bb), .fil1_status(fil1_status),
    .fil2_status(fil2_status));

  // Crystal of 3.6864 MHz built from a phase accumulator on the 50 MHz clock
  always @(posedge clock) begin
    if (ph + 2 * adio_pkg::MASTER_CLK_HZ / 100 >= adio_pkg::CLK_HZ / 100) begin
      ph <= ph + 2 * adio_pkg::MASTER_CLK_HZ / 100 - adio_pkg::CLK_HZ / 100;
      master_clk_in <= ~master_clk_in;
    end else begin
      ph <= ph + 2 * adio_pkg::MASTER_CLK_HZ / 100;
    end
    if (cnt_on && master_clk_in && !m_q) m_rise++;
    if (cnt_on && cpu_clk_out !== c_q) c_tog++;
    m_q <= master_clk_in;
    c_q <= cpu_clk_out;
  end

  task automatic test_done;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic reg_write(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] ad, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  // Counts edges until the system reset lets go, bounded
  task automatic wait_rst;
    int n;
    n = 0;
    while (sys_rst_n !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1 n++;
    end
    chk("rst_release_window", 16'((n >= 15) && (n <= 18)), 16'h0001);
    if (n >= 40) test_done;
  endtask : wait_rst

  task automatic chk_map(input logic [15:0] x);
    chk("ram_ce_n", 16'(ram_ce_n), 16'(x[15] | main_power_low));
    chk("io_page_n", 16'(io_page_n), 16'(x[15:8] != 8'h80));
    chk("rom_ce_n", 16'(rom_ce_n), 16'(!(x[15] && x[15:8] != 8'h80)));
    chk("periph_sel_n", 16'(periph_sel_n),
        {8'h00, ((x[15:8] == 8'h80) ? ~(8'h01 << x[7:5]) : 8'hFF)});
    chk("active_selects", 16'($countones(~{ram_ce_n, rom_ce_n, periph_sel_n})),
        16'(!(main_power_low && !x[15])));
  endtask : chk_map

  initial begin
    rst_n = 1'b0; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
    reg_wdata = 8'h00; supply_good = 1'b1; main_power_low = 1'b0; emission_good = 1'b0;
    fetch_time = 1'b0; next_addr = 16'h0000; cnt_on = 1'b0;
    repeat (8) @(posedge clock);
    chk("sys_rst_n_in_reset", 16'(sys_rst_n), 16'h0000);
    chk("drives_in_reset", 16'({tp, fr, og, em, pg, bb}), 16'h003F);
    rst_n <= 1'b1;
    wait_rst;
    foreach (tbl[i]) begin
      @(posedge clock);
      next_addr <= tbl[i];
      repeat (2) @(posedge clock);
      #1 chk_map(tbl[i]);
    end
    // Date and time fetch lands in the clock block
    @(posedge clock);
    fetch_time <= 1'b1;
    next_addr  <= 16'h0013;
    repeat (2) @(posedge clock);
    #1 chk_map(16'h8093);
    @(posedge clock);
    fetch_time     <= 1'b0;
    main_power_low <= 1'b1;
    next_addr      <= 16'h1234;
    repeat (2) @(posedge clock);
    #1 chk_map(16'h1234);
    @(posedge clock);
    main_power_low <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk_map(16'h1234);
    for (int i = 0; i < 8; i++) begin
      v = (i < 6) ? (8'h01 << i) : ((i == 6) ? 8'h3F : 8'h00);
      reg_write(adio_pkg::REG_CTRL, v);
      emission_good <= ~emission_good;
      repeat (3) @(posedge clock);
      #1 chk("total_pressure_rf_ctrl", 16'(tp), 16'(!v[adio_pkg::CTRL_TOTAL_PRESSURE_RF_CTRL]));
      chk("fil_relay", 16'(fr), 16'(!v[adio_pkg::CTRL_FIL_SEL]));
      chk("outgas", 16'(og), 16'(!v[adio_pkg::CTRL_OUTGAS]));
      chk("multiplier", 16'(em), 16'(!v[adio_pkg::CTRL_EM_EN]));
      chk("preamp", 16'(pg), 16'(!v[adio_pkg::CTRL_PREAMP]));
      chk("beam_blank", 16'(bb), 16'(!v[adio_pkg::CTRL_BEAM_OFF]));
      chk("fil_status", 16'({fil2_status, fil1_status}),
          16'({emission_good & v[1], emission_good & !v[1]}));
      reg_read(adio_pkg::REG_CTRL, rd);
      chk("ctrl_readback", 16'(rd), 16'(v & 8'h3F));
    end
    reg_write(adio_pkg::REG_STATUS, 8'hFF);
    reg_read(4'hC, rd);
    chk("unmapped_read", 16'(rd), 16'h0000);
    reg_read(adio_pkg::REG_CTRL, rd);
    chk("ctrl_after_status_write", 16'(rd), 16'h0000);
    reg_read(adio_pkg::REG_STATUS, rd);
    chk("status", 16'(rd & ~(8'h01 << adio_pkg::ST_CPU_CLK)),
        16'((1 << adio_pkg::ST_SUPPLY_GOOD) | (1 << adio_pkg::ST_SYS_RST_N)));
    reg_read(adio_pkg::REG_DECODE, rd);
    chk("decode", 16'(rd), 16'({next_addr[7:5], 2'b00}));
    // Divided clock must toggle once per crystal rising edge
    @(posedge clock);
    cnt_on <= 1'b1;
    repeat (400) @(posedge clock);
    cnt_on <= 1'b0;
    #1 chk("div_toggles", 16'((c_tog >= m_rise - 1) && (c_tog <= m_rise + 1) && m_rise > 20),
           16'h0001);
    @(posedge clock);
    supply_good <= 1'b0;
    repeat (3) @(posedge clock);
    #1 chk("sys_rst_n_supply_bad", 16'(sys_rst_n), 16'h0000);
    @(posedge clock);
    supply_good <= 1'b1;
    clk_en      <= 1'b0;
    repeat (10) @(posedge clock);
    #1 chk("sys_rst_n_frozen", 16'(sys_rst_n), 16'h0000);
    @(posedge clock);
    clk_en <= 1'b1;
    wait_rst;
    test_done;
  end
endmodule : address_decode_and_control_io_tb
`default_nettype wire
